// >>> mlcf_pkg.sv
`default_nettype none
package mlcf_pkg;
  // ----------------------------------------
  // frame format
  // ----------------------------------------
  localparam logic [7:0] MLCF_SYNC = 8'hAA;
  localparam logic [15:0] MLCF_LEN_ZERO = 16'h0000;
  localparam logic [15:0] MLCF_LEN_ONE = 16'h0001;
  localparam logic [7:0] MLCF_SUM_OK = 8'h00;
  localparam int MLCF_PARAM_KEEP = 4;
  // ----------------------------------------
  // checksum failure report
  // ----------------------------------------
  localparam logic [7:0] MLCF_ERR_OP = 8'hE0;
  localparam logic [7:0] MLCF_ERR_CHKSUM = 8'h01;
  localparam logic [15:0] MLCF_ERR_LEN = 16'h0002;
  localparam logic [2:0] MLCF_ERR_LAST = 3'h5;
  // ----------------------------------------
  // low-mode packet header values
  // ----------------------------------------
  localparam logic [7:0] MLCF_HDR_TEST = 8'h01;
  localparam logic [7:0] MLCF_HDR_CFG = 8'h02;
  localparam logic [7:0] MLCF_HDR_PROG = 8'h03;
  // ----------------------------------------
  // buffer and reset values
  // ----------------------------------------
  localparam int MLCF_FIFO_W = 8;
  localparam int MLCF_FIFO_D = 16;
  localparam logic MLCF_MODE_RST = 1'b1;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MLCF_ST_IDLE = 3'h0,
    MLCF_ST_LEN_H = 3'h1,
    MLCF_ST_LEN_L = 3'h2,
    MLCF_ST_OPC = 3'h3,
    MLCF_ST_PARAM = 3'h4,
    MLCF_ST_CSUM = 3'h5
  } mlcf_state_t;
  typedef enum logic [1:0] {
    MLCF_K_NONE = 2'h0,
    MLCF_K_TEST = 2'h1,
    MLCF_K_CFG = 2'h2,
    MLCF_K_PROG = 2'h3
  } mlcf_kind_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] len;
    logic [31:0] params;
  } mlcf_cmd_t;
  typedef struct packed {
    mlcf_kind_t kind;
    logic [7:0] data;
  } mlcf_low_t;
endpackage
`default_nettype wire

// >>> mlcf_framer.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// byte fifo
// ----------------------------------------
module mlcf_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) cnt_next = cnt_reg + 1'b1;
    else if (pop && !push) cnt_next = cnt_reg - 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_next;
      // registered full flag keeps the fill-side ready a clean flop
      in_ready <= (cnt_next != (AW+1)'(D));
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_reg] <= in_data;
  end
endmodule // mlcf_fifo

// Operation
// - the mode pin level is caught in the first reset cycle and held until the next reset.
// - a low caught level selects the test, configuration and programming family instead of framed commands.
// - a high caught level selects run mode, driven by the framed command protocol.
// - the serial path opens only once the selected mode is entered, and its protocol follows that mode.
// - in the low family each packet's header value picks test, configuration or programming.
// - a frame is sync 0xAA, two length bytes, opcode, parameters and a checksum at length plus three.
// - length comes high byte first and counts the opcode and parameter bytes only.
// - the checksum makes the 8-bit sum of length, opcode and parameters zero, sync excluded.
// - a frame failing its checksum is not executed and a failure report goes back to the host.
// - run mode carries 8 data bits, no parity, one stop bit at a configurable rate.
module mlcf_framer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // mode
  input wire logic mode_select_pin,
  output logic app_mode,
  output logic uart_enable,
  // received bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // executed commands and checksum failures
  output logic cmd_valid,
  output mlcf_pkg::mlcf_cmd_t cmd,
  output logic chk_fail,
  // low-mode bytes
  output logic low_valid,
  output mlcf_pkg::mlcf_low_t low,
  // reply bytes
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  import mlcf_pkg::*;

  function automatic logic [7:0] err_byte(input logic [2:0] idx);
    logic [7:0] s;
    s = MLCF_ERR_LEN[15:8] + MLCF_ERR_LEN[7:0] + MLCF_ERR_OP + MLCF_ERR_CHKSUM;
    case (idx)
      3'h0: err_byte = MLCF_SYNC;
      3'h1: err_byte = MLCF_ERR_LEN[15:8];
      3'h2: err_byte = MLCF_ERR_LEN[7:0];
      3'h3: err_byte = MLCF_ERR_OP;
      3'h4: err_byte = MLCF_ERR_CHKSUM;
      default: err_byte = MLCF_SUM_OK - s;
    endcase
  endfunction

  function automatic mlcf_kind_t hdr_kind(input logic [7:0] b, input mlcf_kind_t cur);
    case (b)
      MLCF_HDR_TEST: hdr_kind = MLCF_K_TEST;
      MLCF_HDR_CFG: hdr_kind = MLCF_K_CFG;
      MLCF_HDR_PROG: hdr_kind = MLCF_K_PROG;
      default: hdr_kind = cur;
    endcase
  endfunction

  // ----------------------------------------
  // mode latch
  // ----------------------------------------
  // power-up value lets the very first reset cycle count as an assertion edge
  logic rst_prev_reg = 1'b0;
  logic mode_reg;
  logic uart_en_reg;
  always_ff @(posedge clk_sys) begin
    rst_prev_reg <= sys_rst;
    if (sys_rst && !rst_prev_reg) mode_reg <= mode_select_pin;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) uart_en_reg <= 1'b0;
    else uart_en_reg <= 1'b1;
  end
  assign app_mode = mode_reg;
  assign uart_enable = uart_en_reg;

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  logic f_valid, f_ready, pop;
  logic [7:0] f_data;
  logic err_pend_reg;
  // the serial side hands over whole 8-bit characters, so the buffer is one byte wide
  mlcf_fifo #(.W(MLCF_FIFO_W), .D(MLCF_FIFO_D)) mlcf_fifo_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(rx_valid && uart_en_reg),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );
  // parsing stalls while a failure report still waits to go out
  assign f_ready = uart_en_reg && !err_pend_reg;
  assign pop = f_valid && f_ready;

  // ----------------------------------------
  // frame parser
  // ----------------------------------------
  mlcf_state_t st_reg;
  logic [15:0] len_reg, cnt_reg;
  logic [7:0] sum_reg, sum_next, opc_reg;
  logic [31:0] par_reg;
  logic app_pop, sum_ok;
  assign app_pop = pop && mode_reg;
  assign sum_next = sum_reg + f_data;
  assign sum_ok = (sum_next == MLCF_SUM_OK);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) st_reg <= MLCF_ST_IDLE;
    else if (app_pop) begin
      unique case (st_reg)
        MLCF_ST_IDLE: if (f_data == MLCF_SYNC) st_reg <= MLCF_ST_LEN_H;
        MLCF_ST_LEN_H: st_reg <= MLCF_ST_LEN_L;
        MLCF_ST_LEN_L: st_reg <= ({len_reg[15:8], f_data} == MLCF_LEN_ZERO) ? MLCF_ST_CSUM : MLCF_ST_OPC;
        MLCF_ST_OPC: st_reg <= (len_reg == MLCF_LEN_ONE) ? MLCF_ST_CSUM : MLCF_ST_PARAM;
        MLCF_ST_PARAM: if (cnt_reg + 16'h0001 == len_reg) st_reg <= MLCF_ST_CSUM;
        MLCF_ST_CSUM: st_reg <= MLCF_ST_IDLE;
        default: st_reg <= MLCF_ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      len_reg <= '0;
      cnt_reg <= '0;
      sum_reg <= '0;
      opc_reg <= '0;
      par_reg <= '0;
    end else if (app_pop) begin
      unique case (st_reg)
        MLCF_ST_LEN_H: begin
          len_reg[15:8] <= f_data;
          sum_reg <= f_data;
        end
        MLCF_ST_LEN_L: begin
          len_reg[7:0] <= f_data;
          sum_reg <= sum_next;
          opc_reg <= '0;
          par_reg <= '0;
        end
        MLCF_ST_OPC: begin
          opc_reg <= f_data;
          sum_reg <= sum_next;
          cnt_reg <= 16'h0001;
        end
        MLCF_ST_PARAM: begin
          // only the leading parameters are kept, the rest still feed the checksum
          // the 2-bit slot index must wrap on its own width, hence the concatenation
          if (cnt_reg <= 16'(MLCF_PARAM_KEEP)) par_reg[{cnt_reg[1:0] - 2'h1, 3'h0} +: 8] <= f_data;
          sum_reg <= sum_next;
          cnt_reg <= cnt_reg + 16'h0001;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // command and failure outputs
  // ----------------------------------------
  logic csum_pop;
  assign csum_pop = app_pop && (st_reg == MLCF_ST_CSUM);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_valid <= 1'b0;
      chk_fail <= 1'b0;
      cmd <= '0;
    end else begin
      cmd_valid <= csum_pop && sum_ok;
      chk_fail <= csum_pop && !sum_ok;
      if (csum_pop && sum_ok) cmd <= '{opcode: opc_reg, len: len_reg, params: par_reg};
    end
  end

  // ----------------------------------------
  // low-mode passthrough
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      low_valid <= 1'b0;
      low <= '{kind: MLCF_K_NONE, data: 8'h00};
    end else begin
      low_valid <= pop && !mode_reg;
      if (pop && !mode_reg) low <= '{kind: hdr_kind(f_data, low.kind), data: f_data};
    end
  end

  // ----------------------------------------
  // failure report sender
  // ----------------------------------------
  logic tx_busy_reg;
  logic [2:0] tx_idx_reg;
  logic tx_start;
  assign tx_start = err_pend_reg && !tx_busy_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) err_pend_reg <= 1'b0;
    else if (csum_pop && !sum_ok) err_pend_reg <= 1'b1;
    else if (tx_start) err_pend_reg <= 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_busy_reg <= 1'b0;
      tx_idx_reg <= '0;
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else if (tx_start) begin
      tx_busy_reg <= 1'b1;
      tx_idx_reg <= '0;
      tx_valid <= 1'b1;
      tx_data <= err_byte(3'h0);
    end else if (tx_valid && tx_ready) begin
      if (tx_idx_reg == MLCF_ERR_LAST) begin
        tx_busy_reg <= 1'b0;
        tx_valid <= 1'b0;
      end else begin
        tx_idx_reg <= tx_idx_reg + 3'h1;
        tx_data <= err_byte(tx_idx_reg + 3'h1);
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_mode_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(app_mode)) else $error("mode changed outside reset");
  a_uart_open: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(sys_rst) |-> !uart_enable ##1 uart_enable) else $error("serial path timing wrong");
  a_low_no_cmd: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !app_mode |-> !cmd_valid && !chk_fail) else $error("command in low mode");
  a_app_no_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    app_mode |-> !low_valid) else $error("low byte in run mode");
  a_low_kind: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pop && !app_mode && f_data == MLCF_HDR_TEST) |=> low_valid && low.kind == MLCF_K_TEST)
    else $error("header kind wrong");
  a_sync_hunt: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (app_pop && st_reg == MLCF_ST_IDLE && f_data != MLCF_SYNC) |=> st_reg == MLCF_ST_IDLE)
    else $error("left hunt without sync");
  a_len_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (app_pop && st_reg == MLCF_ST_OPC && len_reg == MLCF_LEN_ONE) |=> st_reg == MLCF_ST_CSUM)
    else $error("length count wrong");
  a_sum_good: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (csum_pop && sum_ok) |=> cmd_valid && !chk_fail ##1 !cmd_valid) else $error("good frame lost");
  a_sum_bad: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (csum_pop && !sum_ok) |=> chk_fail && !cmd_valid ##[1:3] tx_valid && tx_data == MLCF_SYNC)
    else $error("bad frame not reported");
  c_good_cmd: cover property (@(posedge clk_sys) disable iff (sys_rst) cmd_valid);
  c_bad_cmd: cover property (@(posedge clk_sys) disable iff (sys_rst) chk_fail ##[1:20] !tx_valid);
  c_low_byte: cover property (@(posedge clk_sys) disable iff (sys_rst) low_valid && low.kind == MLCF_K_PROG);
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (sys_rst) uart_enable && !rx_ready);
endmodule // mlcf_framer
`default_nettype wire

// >>> mlcf_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// host model
// ----------------------------------------
module mlcf_host (
  // clock
  input wire logic clk_sys,
  // bytes to the block
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // replies from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  import mlcf_pkg::*;
  logic [1:0] mode = 2'h0;
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // mode 0 prompt, 1 every other cycle, 2 stopped
  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
    tx_ready <= (mode == 2'h0) || (mode == 2'h1 && !tx_ready);
  end
  // released line shows the inverse, so a stale byte never looks valid
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(negedge clk_sys);
    while (rx_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  task automatic send_frame(input logic [7:0] op, input logic [7:0] prm[$], input logic bad);
    logic [15:0] len;
    logic [7:0] sum;
    len = 16'(prm.size() + 1);
    sum = len[15:8] + len[7:0] + op;
    foreach (prm[i]) sum = sum + prm[i];
    send_byte(MLCF_SYNC);
    send_byte(len[15:8]);
    send_byte(len[7:0]);
    send_byte(op);
    foreach (prm[i]) send_byte(prm[i]);
    send_byte((8'h00 - sum) ^ {7'h00, bad});
  endtask
endmodule // mlcf_host
`default_nettype wire

// >>> mlcf_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// framer bench
// ----------------------------------------
module mlcf_framer_tb;
  import mlcf_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic mode_select_pin = 1'b1;
  logic rx_valid, rx_ready, app_mode, uart_enable, cmd_valid, chk_fail, low_valid, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  mlcf_cmd_t cmd;
  mlcf_low_t low;
  int fail_count = 0, compares = 0, cycles = 0, n_cmd = 0, n_fail = 0, n_low = 0;
  logic [7:0] q[$];
  always #50 clk_sys = ~clk_sys;
  mlcf_framer mlcf_framer_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .mode_select_pin(mode_select_pin),
    .app_mode(app_mode), .uart_enable(uart_enable), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .cmd_valid(cmd_valid), .cmd(cmd), .chk_fail(chk_fail), .low_valid(low_valid),
    .low(low), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  mlcf_host mlcf_host_i (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  always @(posedge clk_sys) begin
    cycles++;
    n_cmd += int'(cmd_valid === 1'b1);
    n_fail += int'(chk_fail === 1'b1);
    n_low += int'(low_valid === 1'b1);
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_for(ref int cnt, input int target);
    for (int i = 0; i < 80 && cnt < target; i++) @(negedge clk_sys);
  endtask
  task automatic check_report(input int base);
    logic [7:0] e[6];
    e = '{MLCF_SYNC, MLCF_ERR_LEN[15:8], MLCF_ERR_LEN[7:0], MLCF_ERR_OP, MLCF_ERR_CHKSUM, 8'h00};
    e[5] = 8'h00 - e[1] - e[2] - e[3] - e[4];
    foreach (e[i]) check("reply byte", mlcf_host_i.got[base + i], e[i]);
  endtask
  // the pin flips after the first reset edge; only the caught level may count
  task automatic t_reset(input logic pin);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    mode_select_pin <= pin;
    @(posedge clk_sys);
    mode_select_pin <= ~pin;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    check("uart_enable in reset", uart_enable, 1'b0);
    check("app_mode", app_mode, pin);
    repeat (2) @(negedge clk_sys);
    check("uart_enable", uart_enable, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_good(input logic [7:0] op, input logic [31:0] p, input int np);
    int c0;
    c0 = n_cmd;
    q = {};
    for (int i = 0; i < np; i++) q.push_back(p[8*i +: 8]);
    mlcf_host_i.send_byte(8'h33);
    mlcf_host_i.send_frame(op, q, 1'b0);
    wait_for(n_cmd, c0 + 1);
    check("cmd count", n_cmd, c0 + 1);
    check("cmd", cmd, {op, 16'(np + 1), p});
    $display("test good frame done");
  endtask
  task automatic t_bad();
    int f0, c0;
    f0 = n_fail;
    c0 = n_cmd;
    mlcf_host_i.got = {};
    mlcf_host_i.mode <= 2'h1;
    q = {8'h05};
    mlcf_host_i.send_frame(8'h01, q, 1'b1);
    wait_for(n_fail, f0 + 1);
    for (int i = 0; i < 80 && mlcf_host_i.got.size() < 6; i++) @(negedge clk_sys);
    check("fail count", n_fail, f0 + 1);
    check("cmd count", n_cmd, c0);
    check_report(0);
    $display("test bad checksum done");
  endtask
  // a second failure waits behind the stalled report, so the parser stops and the fifo fills
  task automatic t_fill();
    int n_in, f0;
    logic full;
    n_in = 0;
    full = 1'b0;
    f0 = n_fail;
    mlcf_host_i.got = {};
    mlcf_host_i.mode <= 2'h2;
    q = {8'h07};
    repeat (2) mlcf_host_i.send_frame(8'h02, q, 1'b1);
    wait_for(n_fail, f0 + 2);
    for (int i = 0; i < 24 && !full; i++) begin
      @(posedge clk_sys);
      rx_valid_drive(1'b1);
      @(negedge clk_sys);
      if (rx_ready !== 1'b1) full = 1'b1;
      else n_in++;
    end
    @(posedge clk_sys);
    rx_valid_drive(1'b0);
    check("fifo full", full, 1'b1);
    check("bytes taken", n_in, MLCF_FIFO_D);
    mlcf_host_i.mode <= 2'h0;
    for (int i = 0; i < 200 && mlcf_host_i.got.size() < 12; i++) @(negedge clk_sys);
    check_report(0);
    check_report(6);
    check("fail count", n_fail, f0 + 2);
    $display("test fifo fill done");
  endtask
  // a zero length means the checksum follows the length at once and the command reports opcode 00
  task automatic t_empty();
    int c0;
    c0 = n_cmd;
    mlcf_host_i.send_byte(MLCF_SYNC);
    repeat (3) mlcf_host_i.send_byte(8'h00);
    wait_for(n_cmd, c0 + 1);
    check("cmd count", n_cmd, c0 + 1);
    check("cmd", cmd, {8'h00, MLCF_LEN_ZERO, 32'h00000000});
    $display("test empty frame done");
  endtask
  task automatic rx_valid_drive(input logic v);
    mlcf_host_i.rx_valid <= v;
    mlcf_host_i.rx_data <= v ? 8'h33 : 8'hCC;
  endtask
  task automatic t_low();
    int l0, c0;
    c0 = n_cmd;
    t_reset(1'b0);
    for (int k = 1; k < 4; k++) begin
      l0 = n_low;
      mlcf_host_i.send_byte(8'(k));
      mlcf_host_i.send_byte(8'h50 + 8'(k));
      wait_for(n_low, l0 + 2);
      check("low", low, {mlcf_kind_t'(k), 8'h50 + 8'(k)});
    end
    check("cmd count", n_cmd, c0);
    $display("test low mode done");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check("app_mode", app_mode, 1'b1);
    check("uart_enable", uart_enable, 1'b1);
    t_good(8'h01, 32'h00000000, 1);
    t_good(8'h11, 32'h44332211, 4);
    t_bad();
    t_fill();
    t_good(8'h21, 32'h0000BEEF, 2);
    t_low();
    t_reset(1'b1);
    t_good(8'h22, 32'h00000000, 0);
    t_empty();
    end_of_test();
  end
endmodule // mlcf_framer_tb
`default_nettype wire
